/* rtl/mia_pkg.sv */
// Constants, register map and types of the management interrupt aggregator.
`default_nettype none

package mia_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // APB geometry. Register indices are word offsets of one word each.
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int IDX_W    = 8;
    localparam int ADDR_LSB = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_EN_A     = 8'hb4;
    localparam logic [IDX_W-1:0] IDX_EN_B     = 8'hb5;
    localparam logic [IDX_W-1:0] IDX_ST_A     = 8'hb6;
    localparam logic [IDX_W-1:0] IDX_ST_B     = 8'hb7;
    localparam logic [IDX_W-1:0] IDX_SPARE    = 8'hb8;
    localparam logic [IDX_W-1:0] IDX_KBD_OPT  = 8'hf0;
    localparam logic [IDX_W-1:0] IDX_KBD_R_LO = 8'hf1;
    localparam logic [IDX_W-1:0] IDX_KBD_R_HI = 8'hff;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int BIT_PAR       = 1;
    localparam int BIT_SER_B     = 2;
    localparam int BIT_SER_A     = 3;
    localparam int BIT_FLOPPY    = 4;
    localparam int BIT_WDOG      = 7;
    localparam int BIT_MOUSE     = 0;
    localparam int BIT_KBD       = 1;
    localparam int BIT_IR        = 2;
    localparam int BIT_KBC       = 4;
    localparam int BIT_FRAME     = 6;
    localparam int BIT_KBC_POL   = 7;
    localparam int BIT_FAST_GATE = 2;

    // Writable or readable bits; everything else reads zero.
    localparam logic [7:0] MASK_A       = 8'h9e;
    localparam logic [7:0] MASK_EN_B    = 8'h57;
    localparam logic [7:0] MASK_SRC_B   = 8'h17;
    localparam logic [7:0] MASK_KBD_OPT = 8'h84;

    // Reset values.
    localparam logic [7:0] RST_EN_A    = 8'h00;
    localparam logic [7:0] RST_EN_B    = 8'h00;
    localparam logic [7:0] RST_KBD_OPT = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Positions of the sources in the synchronised vector.
    localparam int SRC_PAR    = 0;
    localparam int SRC_SER_B  = 1;
    localparam int SRC_SER_A  = 2;
    localparam int SRC_FLOPPY = 3;
    localparam int SRC_WDOG   = 4;
    localparam int SRC_MOUSE  = 5;
    localparam int SRC_KBD    = 6;
    localparam int SRC_IR     = 7;
    localparam int SRC_KBC    = 8;
    localparam int NUM_SRC    = 9;

    // Cycles after reset during which the IR edge detector stays blind.
    localparam logic [2:0] EDGE_HOLDOFF = 3'h5;

    typedef enum logic [0:0] {
        MIA_IDLE = 1'b0,
        MIA_ACK  = 1'b1
    } mia_apb_state_t;

endpackage

`default_nettype wire

/* rtl/mia_src_if.sv */
// Carrier of synchronised source levels and the IR edge pulse.
`timescale 1ns/1ps
`default_nettype none

interface mia_src_if #(
    parameter int W = 9
);
    logic [W-1:0] level;
    logic         ir_edge;

    modport sync_mp (output level);
    modport edge_mp (input level, output ir_edge);
    modport core_mp (input level, input ir_edge);
endinterface

`default_nettype wire

/* rtl/mia_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none

module mia_sync #(
    parameter int W = 9
) (
    input  wire logic   clk_sys,
    input  wire logic   rst,
    input  wire logic [W-1:0] async_in,
    mia_src_if.sync_mp  sif
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] filt_reg;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A bit only moves once the second and third stages agree.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            filt_reg <= '0;
        end else begin
            filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
        end
    end

    assign sif.level = filt_reg;

endmodule // mia_sync

`default_nettype wire

/* rtl/mia_edge_det.sv */
// Transition detector on one synchronised level, with a short blind time after reset.
`timescale 1ns/1ps
`default_nettype none

module mia_edge_det
    import mia_pkg::*;
#(
    parameter int IDX = 7
) (
    input  wire logic  clk_sys,
    input  wire logic  rst,
    mia_src_if.edge_mp sif
);
    logic       prev_reg;
    logic       edge_reg;
    logic [2:0] hold_reg;

    // The filtered level starts at zero, so an idle-high pin would look like an edge.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_reg <= EDGE_HOLDOFF;
        end else if (hold_reg != 3'h0) begin
            hold_reg <= hold_reg - 3'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prev_reg <= 1'b0;
            edge_reg <= 1'b0;
        end else begin
            prev_reg <= sif.level[IDX];
            edge_reg <= (sif.level[IDX] ^ prev_reg) & (hold_reg == 3'h0);
        end
    end

    assign sif.ir_edge = edge_reg;

endmodule // mia_edge_det

`default_nettype wire

/* rtl/mia_top.sv */
// Management interrupt aggregator: APB registers, source status and combined interrupt.
`timescale 1ns/1ps
`default_nettype none

module mia_top
    import mia_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              par_port_irq,
    input  wire logic              serial_b_irq,
    input  wire logic              serial_a_irq,
    input  wire logic              floppy_irq,
    input  wire logic              watchdog_irq,
    input  wire logic              mouse_irq,
    input  wire logic              keyboard_irq,
    input  wire logic              infrared_receive_pin,
    input  wire logic              serial_b_receive_pin,
    input  wire logic              ir_rx_pin_select,
    input  wire logic              kbc_port1_bit2,
    output logic                   mgmt_irq_n,
    output logic                   mgmt_irq_serial_frame,
    output logic                   fast_gate_port_en
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.
    mia_apb_state_t    state_reg;
    logic [7:0]        enable_a_reg;
    logic [7:0]        enable_b_reg;
    logic [7:0]        kbd_opt_reg;
    logic              ir_flag_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic              pready_reg;
    logic              pslverr_reg;
    logic              mgmt_irq_n_reg;
    logic              frame_reg;
    logic              fast_gate_reg;

    logic [NUM_SRC-1:0] async_src;
    logic               ir_muxed;
    logic [IDX_W-1:0]   idx;
    logic               aligned;
    logic               hit;
    logic               access;
    logic               capture;
    logic               commit_wr;
    logic               kbc_active;
    logic [7:0]         status_a;
    logic [7:0]         status_b;
    logic [7:0]         rd_byte;
    logic               pending;

    mia_src_if #(.W(NUM_SRC)) src_if ();

    ////////////////////////////////////////////////////////////////////////////
    // Source synchronisation and IR edge detection.
    assign ir_muxed = ir_rx_pin_select ? infrared_receive_pin : serial_b_receive_pin;

    assign async_src = {kbc_port1_bit2, ir_muxed, keyboard_irq, mouse_irq, watchdog_irq,
                        floppy_irq, serial_a_irq, serial_b_irq, par_port_irq};

    mia_sync #(
        .W (NUM_SRC)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (async_src),
        .sif      (src_if.sync_mp)
    );

    mia_edge_det #(
        .IDX (SRC_IR)
    ) u_edge (
        .clk_sys (clk_sys),
        .rst     (rst),
        .sif     (src_if.edge_mp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Status assembly; levels follow their sources and ignore the enables.
    assign kbc_active = src_if.level[SRC_KBC] ^ ~kbd_opt_reg[BIT_KBC_POL];

    always_comb begin
        status_a             = 8'h00;
        status_a[BIT_PAR]    = src_if.level[SRC_PAR];
        status_a[BIT_SER_B]  = src_if.level[SRC_SER_B];
        status_a[BIT_SER_A]  = src_if.level[SRC_SER_A];
        status_a[BIT_FLOPPY] = src_if.level[SRC_FLOPPY];
        status_a[BIT_WDOG]   = src_if.level[SRC_WDOG];
    end

    always_comb begin
        status_b            = 8'h00;
        status_b[BIT_MOUSE] = src_if.level[SRC_MOUSE];
        status_b[BIT_KBD]   = src_if.level[SRC_KBD];
        status_b[BIT_IR]    = ir_flag_reg;
        status_b[BIT_KBC]   = kbc_active;
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB decode.
    // Only indices that fit the index width decode; higher address bits must be zero.
    assign idx     = paddr[ADDR_LSB+IDX_W-1:ADDR_LSB];
    assign aligned = (paddr[ADDR_LSB-1:0] == '0) && (paddr[ADDR_W-1:ADDR_LSB+IDX_W] == '0);

    always_comb begin
        hit = 1'b0;
        if (aligned) begin
            if ((idx >= IDX_EN_A) && (idx <= IDX_SPARE)) begin
                hit = 1'b1;
            end
            if ((idx == IDX_KBD_OPT) || ((idx >= IDX_KBD_R_LO) && (idx <= IDX_KBD_R_HI))) begin
                hit = 1'b1;
            end
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            IDX_EN_A:    rd_byte = enable_a_reg;
            IDX_EN_B:    rd_byte = enable_b_reg;
            IDX_ST_A:    rd_byte = status_a;
            IDX_ST_B:    rd_byte = status_b;
            IDX_KBD_OPT: rd_byte = kbd_opt_reg;
            default:     rd_byte = 8'h00;
        endcase
    end

    // Read data is captured one edge before the completing edge.
    assign access    = psel && penable;
    assign capture   = access && (state_reg == MIA_IDLE);
    assign commit_wr = access && (state_reg == MIA_ACK) && pwrite && hit;

    ////////////////////////////////////////////////////////////////////////////
    // APB handshake: one wait state, pready and the answer come from flops.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= MIA_IDLE;
        end else begin
            case (state_reg)
                MIA_IDLE: begin
                    if (capture) begin
                        state_reg <= MIA_ACK;
                    end
                end
                MIA_ACK: state_reg <= MIA_IDLE;
                default: state_reg <= MIA_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else if (capture) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= ~hit;
            prdata_reg  <= (pwrite || !hit) ? '0 : {{(DATA_W-8){1'b0}}, rd_byte};
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Writable registers; reserved bits are never stored.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enable_a_reg <= RST_EN_A;
        end else if (commit_wr && (idx == IDX_EN_A)) begin
            enable_a_reg <= pwdata[7:0] & MASK_A;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enable_b_reg <= RST_EN_B;
        end else if (commit_wr && (idx == IDX_EN_B)) begin
            enable_b_reg <= pwdata[7:0] & MASK_EN_B;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            kbd_opt_reg <= RST_KBD_OPT;
        end else if (commit_wr && (idx == IDX_KBD_OPT)) begin
            kbd_opt_reg <= pwdata[7:0] & MASK_KBD_OPT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // IR edge flag: a read clears it, a new edge in the same cycle wins.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ir_flag_reg <= 1'b0;
        end else if (src_if.ir_edge) begin
            ir_flag_reg <= 1'b1;
        end else if (capture && !pwrite && hit && (idx == IDX_ST_B)) begin
            ir_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Combined interrupt, serial frame request and keyboard options.
    assign pending = |(status_a & enable_a_reg)
                   | |(status_b & enable_b_reg & MASK_SRC_B);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mgmt_irq_n_reg <= 1'b1;
            frame_reg      <= 1'b0;
        end else begin
            mgmt_irq_n_reg <= ~pending;
            frame_reg      <= pending & enable_b_reg[BIT_FRAME];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fast_gate_reg <= 1'b0;
        end else begin
            fast_gate_reg <= kbd_opt_reg[BIT_FAST_GATE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign prdata                = prdata_reg;
    assign pready                = pready_reg;
    assign pslverr               = pslverr_reg;
    assign mgmt_irq_n            = mgmt_irq_n_reg;
    assign mgmt_irq_serial_frame = frame_reg;
    assign fast_gate_port_en     = fast_gate_reg;

endmodule // mia_top

`default_nettype wire

/* dv/mia_top_sva.sv */
// Port checker for the management interrupt aggregator.
`timescale 1ns/1ps
`default_nettype none
module mia_top_sva
    import mia_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              mgmt_irq_n,
    input wire logic              mgmt_irq_serial_frame,
    input wire logic              fast_gate_port_en
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // Read data seen at the completing edge.
    logic rd_ok;
    logic wr_done;
    assign rd_ok = pready && !pwrite && !pslverr;
    assign wr_done = psel && penable && pwrite && pready;
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_err_bad; pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0; endproperty
    a_err_bad: assert property (p_err_bad) else $error("unaligned access not refused");
    property p_en_a_mask; rd_ok && paddr == 12'h2d0 |-> (prdata & 32'hffffff61) == 32'h0; endproperty
    a_en_a_mask: assert property (p_en_a_mask) else $error("enable A reserved bit set");
    property p_en_b_mask; rd_ok && paddr == 12'h2d4 |-> (prdata & 32'hffffffa8) == 32'h0; endproperty
    a_en_b_mask: assert property (p_en_b_mask) else $error("enable B reserved bit set");
    property p_frame; mgmt_irq_serial_frame |-> !mgmt_irq_n; endproperty
    a_frame: assert property (p_frame) else $error("frame without pending interrupt");
    property p_st_a; rd_ok && paddr == 12'h2d8 |-> (prdata & 32'hffffff61) == 32'h0; endproperty
    a_st_a: assert property (p_st_a) else $error("status A reserved bit set");
    property p_st_b; rd_ok && paddr == 12'h2dc |-> (prdata & 32'hffffffe8) == 32'h0; endproperty
    a_st_b: assert property (p_st_b) else $error("status B reserved bit set");
    property p_gate_set; wr_done && paddr == 12'h3c0 |-> ##2 fast_gate_port_en == $past(pwdata[2], 2);
    endproperty
    a_gate_set: assert property (p_gate_set) else $error("fast gate not written");
    property p_gate_hold; !wr_done && !$past(wr_done) |=> $stable(fast_gate_port_en); endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("fast gate changed alone");
    property p_kbd_zero; rd_ok && paddr[11:6] == 6'h0f && paddr[5:2] != 4'h0 |-> prdata == 32'h0;
    endproperty
    a_kbd_zero: assert property (p_kbd_zero) else $error("keyboard spare index not zero");
endmodule // mia_top_sva
bind mia_top mia_top_sva u_sva (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mgmt_irq_n, .mgmt_irq_serial_frame, .fast_gate_port_en);
`default_nettype wire

/* dv/mia_src_model.sv */
// Model of the peripherals that drive the source and receive lines.
`timescale 1ns/1ps
`default_nettype none
module mia_src_model (
    input  wire logic       clk_sys,
    input  wire logic [9:0] want,
    output logic      [9:0] lines
);
    // Keyboard-controller line idles high, which is inactive at reset polarity.
    logic [9:0] lvl_reg = 10'h200;
    // A source condition is removed only by its own peripheral.
    always @(posedge clk_sys) begin
        lvl_reg <= want;
    end
    assign lines = lvl_reg;
endmodule // mia_src_model
`default_nettype wire

/* dv/mia_top_bench.sv */
// Register-level testbench of the management interrupt aggregator.
`timescale 1ns/1ps
`default_nettype none
module mia_top_bench;
    import mia_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_n;
    logic        frame;
    logic        gate;
    logic        ir_sel = 1'b0;
    logic [9:0]  want = 10'h200;
    logic [9:0]  ln;
    logic [31:0] got;
    logic        err;
    int          n_fail = 0;
    int          n_compared = 0;
    int          pos[7] = '{1, 2, 3, 4, 7, 0, 1};
    always #2.5 clk_sys = ~clk_sys;
    mia_src_model u_src (.clk_sys(clk_sys), .want(want), .lines(ln));
    mia_top uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .par_port_irq(ln[0]), .serial_b_irq(ln[1]), .serial_a_irq(ln[2]), .floppy_irq(ln[3]),
        .watchdog_irq(ln[4]), .mouse_irq(ln[5]), .keyboard_irq(ln[6]),
        .infrared_receive_pin(ln[7]), .serial_b_receive_pin(ln[8]), .ir_rx_pin_select(ir_sel),
        .kbc_port1_bit2(ln[9]), .mgmt_irq_n(irq_n), .mgmt_irq_serial_frame(frame),
        .fast_gate_port_en(gate));
    ////////////////////////////////////////
    task give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n == 16) begin
            n_fail++;
            give_verdict();
        end
        got = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] i, input logic [31:0] e);
        apb(1'b0, ad(i), 32'h0);
        chk(got, e);
    endtask
    task settle;
        repeat (12) @(posedge clk_sys);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 8'hb4; i <= 8'hb8; i++) rd(i[7:0], 32'h0);
        rd(IDX_KBD_OPT, 32'h0);
        chk(irq_n, 1);
        $display("Reset values done");
        apb(1'b1, ad(IDX_EN_A), 32'hffffffff);
        rd(IDX_EN_A, 32'h9e);
        apb(1'b1, ad(IDX_EN_B), 32'hffffffff);
        rd(IDX_EN_B, 32'h57);
        apb(1'b1, ad(IDX_KBD_OPT), 32'h7f);
        rd(IDX_KBD_OPT, 32'h04);
        chk(gate, 1);
        apb(1'b1, ad(IDX_ST_A), 32'hff);
        rd(IDX_ST_A, 32'h0);
        for (int i = 8'hf1; i <= 8'hff; i++) begin
            apb(1'b1, ad(i[7:0]), 32'hff);
            rd(i[7:0], 32'h0);
        end
        apb(1'b0, 12'h004, 32'h0);
        chk(err, 1);
        apb(1'b0, 12'h2d1, 32'h0);
        chk(err, 1);
        $display("Register map done");
        for (int k = 0; k < 7; k++) begin
            want[k] <= 1'b1;
            settle();
            rd(k < 5 ? IDX_ST_A : IDX_ST_B, 32'h1 << pos[k]);
            chk({irq_n, frame}, 2'b01);
            apb(1'b1, ad(k < 5 ? IDX_EN_A : IDX_EN_B), 32'h0);
            settle();
            rd(k < 5 ? IDX_ST_A : IDX_ST_B, 32'h1 << pos[k]);
            chk({irq_n, frame}, 2'b10);
            apb(1'b1, ad(k < 5 ? IDX_EN_A : IDX_EN_B), k < 5 ? 32'h9e : 32'h57);
            want[k] <= 1'b0;
            settle();
            rd(k < 5 ? IDX_ST_A : IDX_ST_B, 32'h0);
            chk(irq_n, 1);
        end
        $display("Source levels done");
        want[9] <= 1'b0;
        settle();
        rd(IDX_ST_B, 32'h10);
        chk(irq_n, 0);
        apb(1'b1, ad(IDX_EN_B), 32'h47);
        settle();
        chk(irq_n, 1);
        apb(1'b1, ad(IDX_EN_B), 32'h57);
        apb(1'b1, ad(IDX_KBD_OPT), 32'h84);
        settle();
        rd(IDX_ST_B, 32'h0);
        want[9] <= 1'b1;
        settle();
        rd(IDX_ST_B, 32'h10);
        apb(1'b1, ad(IDX_KBD_OPT), 32'h04);
        settle();
        chk(irq_n, 1);
        $display("Keyboard line done");
        for (int s = 0; s < 2; s++) begin
            ir_sel <= s[0];
            settle();
            apb(1'b0, ad(IDX_ST_B), 32'h0);
            want[s ? 7 : 8] <= ~want[s ? 7 : 8];
            settle();
            chk(irq_n, 0);
            rd(IDX_ST_B, 32'h04);
            rd(IDX_ST_B, 32'h0);
            want[s ? 8 : 7] <= ~want[s ? 8 : 7];
            settle();
            rd(IDX_ST_B, 32'h0);
        end
        $display("Receive edge done");
        give_verdict();
    end
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end
endmodule // mia_top_bench
`default_nettype wire
